// >>> core/psoc_top.v
/*
 * Page select and operation command decoder for a 16-channel supply manager.
 * Assumes a byte-level command port from the serial bus engine, synchronous to mclk.
 */
`timescale 1ns/1ps
`include "psoc_defs.vh"

module psoc_top #(
  parameter NCHAN = 16
) (
  mclk,
  rst,
  cmd_valid,
  cmd_write,
  cmd_code,
  cmd_wdata,
  cmd_done,
  cmd_rdata,
  onoff_enable,
  chan_enabled,
  all_power_good,
  pin_on,
  pin_off,
  supply_enable_output,
  off_immediate,
  group_seq,
  margin_low,
  margin_high,
  fault_suppress,
  sel_chan,
  sel_dac_addr,
  sel_margin_dac_output,
  sel_temp_addr,
  sel_temp_internal,
  sel_is_temp,
  sel_is_all,
  cml_status,
  alert_o,
  alert_oe
);
  input wire mclk;
  input wire rst;
  input wire cmd_valid;
  input wire cmd_write;
  input wire [7:0] cmd_code;
  input wire [7:0] cmd_wdata;
  output reg cmd_done;
  output reg [7:0] cmd_rdata;
  input wire onoff_enable;
  input wire [NCHAN-1:0] chan_enabled;
  input wire all_power_good;
  input wire pin_on;
  input wire pin_off;
  output wire [NCHAN-1:0] supply_enable_output;
  output wire [NCHAN-1:0] off_immediate;
  output wire [NCHAN-1:0] group_seq;
  output wire [NCHAN-1:0] margin_low;
  output wire [NCHAN-1:0] margin_high;
  output wire [NCHAN-1:0] fault_suppress;
  output reg [3:0] sel_chan;
  output reg [7:0] sel_dac_addr;
  output reg [1:0] sel_margin_dac_output;
  output reg [7:0] sel_temp_addr;
  output reg sel_temp_internal;
  output reg sel_is_temp;
  output reg sel_is_all;
  output reg cml_status;
  output wire alert_o;
  output wire alert_oe;

  function op_code_ok;
    input [7:0] b;
    begin
      case (b)
        `PSOC_OP_OFF_NOW, `PSOC_OP_OFF_SOFT, `PSOC_OP_ON,
        `PSOC_OP_LOW_IGN, `PSOC_OP_LOW_ACT,
        `PSOC_OP_HIGH_IGN, `PSOC_OP_HIGH_ACT: op_code_ok = 1'b1;
        default: op_code_ok = 1'b0;
      endcase
    end
  endfunction

  function chan_hit;
    input sel_all;
    input sel_one;
    input [3:0] idx;
    input integer ch;
    begin
      chan_hit = sel_all || (sel_one && (idx == ch[3:0]));
    end
  endfunction

  reg [7:0] page_select_reg;
  reg alert_reg;
  reg [7:0] rdata_next;
  wire [7:0] op_byte [0:NCHAN-1];

  wire cur_valid;
  wire cur_chan;
  wire cur_temp;
  wire cur_all;
  wire [3:0] cur_idx;
  wire [7:0] cur_dac;
  wire [1:0] cur_dacout;
  wire [7:0] cur_taddr;
  wire cur_tint;

  wire new_valid;
  wire new_chan;
  wire new_temp;
  wire new_all;
  wire [3:0] new_idx;
  wire [7:0] new_dac;
  wire [1:0] new_dacout;
  wire [7:0] new_taddr;
  wire new_tint;

  psoc_page_decode u_cur (
    .page(page_select_reg),
    .page_valid(cur_valid),
    .is_chan(cur_chan),
    .is_temp(cur_temp),
    .is_all(cur_all),
    .chan_idx(cur_idx),
    .dac_addr(cur_dac),
    .dac_output(cur_dacout),
    .temp_addr(cur_taddr),
    .temp_internal(cur_tint)
  );

  // Decode of the incoming value lets the select outputs follow the write
  psoc_page_decode u_new (
    .page(cmd_wdata),
    .page_valid(new_valid),
    .is_chan(new_chan),
    .is_temp(new_temp),
    .is_all(new_all),
    .chan_idx(new_idx),
    .dac_addr(new_dac),
    .dac_output(new_dacout),
    .temp_addr(new_taddr),
    .temp_internal(new_tint)
  );

  wire wr_cmd;
  wire rd_cmd;
  wire op_cmd;
  wire op_ok;
  wire wr_page;
  wire wr_op;
  wire wr_clear;
  wire op_supported;
  wire err_page;
  wire err_op_page;
  wire err_op_data;
  wire err_cmd;
  wire cml_set;

  assign wr_cmd = cmd_valid && cmd_write;
  assign rd_cmd = cmd_valid && !cmd_write;
  assign op_cmd = cmd_valid && (cmd_code == `PSOC_CMD_OPERATION);
  assign wr_page = wr_cmd && (cmd_code == `PSOC_CMD_PAGE);
  assign wr_op = wr_cmd && (cmd_code == `PSOC_CMD_OPERATION);
  assign wr_clear = wr_cmd && (cmd_code == `PSOC_CMD_CLEAR_FAULTS);
  assign op_supported = cur_chan || cur_all;
  assign err_page = wr_page && !new_valid;
  assign err_op_page = op_cmd && !op_supported;
  assign err_op_data = wr_op && op_supported && !op_code_ok(cmd_wdata);
  // Clear faults is write-only; a read of it is unsupported on every page
  assign err_cmd = rd_cmd && (cmd_code == `PSOC_CMD_CLEAR_FAULTS);
  assign cml_set = err_page || err_op_page || err_op_data || err_cmd;
  // Validity is decoded once and shared by every channel
  assign op_ok = wr_op && op_code_ok(cmd_wdata);

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      page_select_reg <= `PSOC_PAGE_RESET;
      sel_chan <= 4'h0;
      sel_dac_addr <= `PSOC_DAC_ADDR_0;
      sel_margin_dac_output <= 2'h0;
      sel_temp_addr <= `PSOC_TEMP_ADDR_NONE;
      sel_temp_internal <= 1'b0;
      sel_is_temp <= 1'b0;
      sel_is_all <= 1'b0;
    end else if (wr_page && new_valid) begin
      // Reserved pages leave the selection unchanged
      page_select_reg <= cmd_wdata;
      sel_chan <= new_idx;
      sel_dac_addr <= new_dac;
      sel_margin_dac_output <= new_dacout;
      sel_temp_addr <= new_taddr;
      sel_temp_internal <= new_tint;
      sel_is_temp <= new_temp;
      sel_is_all <= new_all;
    end
  end

  // Set wins over a clear in the same cycle
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cml_status <= 1'b0;
    end else if (cml_set) begin
      cml_status <= 1'b1;
    end else if (wr_clear) begin
      cml_status <= 1'b0;
    end
  end

  // Alert follows the same events; the pin itself is open drain
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      alert_reg <= 1'b0;
    end else if (cml_set) begin
      alert_reg <= 1'b1;
    end else if (wr_clear) begin
      alert_reg <= 1'b0;
    end
  end

  assign alert_o = 1'b0;
  assign alert_oe = alert_reg;

  // Unknown codes read as zero so a stale byte never leaks out
  always @* begin
    rdata_next = cmd_rdata;
    if (rd_cmd) begin
      case (cmd_code)
        `PSOC_CMD_PAGE: rdata_next = page_select_reg;
        `PSOC_CMD_OPERATION: rdata_next = op_supported ? op_byte[cur_idx] : 8'h00;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmd_done <= 1'b0;
    end else begin
      cmd_done <= cmd_valid;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmd_rdata <= 8'h00;
    end else begin
      cmd_rdata <= rdata_next;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCHAN; g = g + 1) begin : g_chan
      wire hit;
      // Page 255 writes every enabled channel together as one sequenced group
      assign hit = op_ok
                   && chan_hit(cur_all, cur_chan, cur_idx, g);
      psoc_chan_ctrl u_chan (
        .mclk(mclk),
        .rst(rst),
        .op_wr(hit),
        .op_data(cmd_wdata),
        .op_group(cur_all),
        .onoff_enable(onoff_enable),
        .chan_enabled(chan_enabled[g]),
        .all_power_good(all_power_good),
        .pin_on(pin_on),
        .pin_off(pin_off),
        .op_byte(op_byte[g]),
        .run_req(supply_enable_output[g]),
        .off_immediate(off_immediate[g]),
        .group_seq(group_seq[g]),
        .margin_low(margin_low[g]),
        .margin_high(margin_high[g]),
        .fault_suppress(fault_suppress[g])
      );
    end
  endgenerate
endmodule

// >>> core/psoc_defs.vh
/*
 * Constants for the page select and operation control block.
 * Assumes inclusion by bare name from the core/ design files.
 */
`ifndef PSOC_DEFS_VH
`define PSOC_DEFS_VH

`define PSOC_CMD_PAGE 8'h00
`define PSOC_CMD_OPERATION 8'h01
`define PSOC_CMD_CLEAR_FAULTS 8'h03

`define PSOC_PAGE_RESET 8'h00
`define PSOC_PAGE_LAST_CHAN 8'h0F
`define PSOC_PAGE_TEMP_INT 8'h11
`define PSOC_PAGE_TEMP_LAST 8'h15
`define PSOC_PAGE_ALL 8'hFF

`define PSOC_DAC_ADDR_0 8'h20
`define PSOC_DAC_ADDR_1 8'h60
`define PSOC_DAC_ADDR_2 8'hA0
`define PSOC_DAC_ADDR_3 8'hE0
`define PSOC_TEMP_ADDR_BASE 8'h90
`define PSOC_TEMP_ADDR_NONE 8'h00

`define PSOC_OP_OFF_NOW 8'h00
`define PSOC_OP_OFF_SOFT 8'h40
`define PSOC_OP_ON 8'h80
`define PSOC_OP_LOW_IGN 8'h94
`define PSOC_OP_LOW_ACT 8'h98
`define PSOC_OP_HIGH_IGN 8'hA4
`define PSOC_OP_HIGH_ACT 8'hA8
`define PSOC_OP_RESET 8'h00

`define PSOC_MARGIN_OFF 2'h0
`define PSOC_MARGIN_LOW 2'h1
`define PSOC_MARGIN_HIGH 2'h2

`endif

// >>> core/psoc_page_decode.v
/*
 * Decodes a page value into its target: supply channel, margin DAC, temperature sensor.
 * Assumes a stable page value; purely combinational.
 */
`timescale 1ns/1ps
`include "psoc_defs.vh"

module psoc_page_decode (
  page,
  page_valid,
  is_chan,
  is_temp,
  is_all,
  chan_idx,
  dac_addr,
  dac_output,
  temp_addr,
  temp_internal
);
  input wire [7:0] page;
  output reg page_valid;
  output reg is_chan;
  output reg is_temp;
  output reg is_all;
  output reg [3:0] chan_idx;
  output reg [7:0] dac_addr;
  output reg [1:0] dac_output;
  output reg [7:0] temp_addr;
  output reg temp_internal;

  always @* begin
    is_chan = (page <= `PSOC_PAGE_LAST_CHAN);
    is_temp = (page >= `PSOC_PAGE_TEMP_INT) && (page <= `PSOC_PAGE_TEMP_LAST);
    is_all = (page == `PSOC_PAGE_ALL);
    page_valid = is_chan || is_temp || is_all;
    chan_idx = page[3:0];
    dac_output = page[1:0];
    case (page[3:2])
      2'h0: dac_addr = `PSOC_DAC_ADDR_0;
      2'h1: dac_addr = `PSOC_DAC_ADDR_1;
      2'h2: dac_addr = `PSOC_DAC_ADDR_2;
      default: dac_addr = `PSOC_DAC_ADDR_3;
    endcase
    temp_internal = (page == `PSOC_PAGE_TEMP_INT);
    // Remote sensors sit at even addresses from the base, one per page
    if (is_temp && !temp_internal) begin
      temp_addr = `PSOC_TEMP_ADDR_BASE + {4'h0, page[2:0] - 3'h2, 1'b0};
    end else begin
      temp_addr = `PSOC_TEMP_ADDR_NONE;
    end
  end
endmodule

// >>> core/psoc_chan_ctrl.v
/*
 * Per-channel on/off and margin state kept from OPERATION writes and control pin events.
 * Assumes the top qualifies writes by page and op code validity.
 */
`timescale 1ns/1ps
`include "psoc_defs.vh"

module psoc_chan_ctrl (
  mclk,
  rst,
  op_wr,
  op_data,
  op_group,
  onoff_enable,
  chan_enabled,
  all_power_good,
  pin_on,
  pin_off,
  op_byte,
  run_req,
  off_immediate,
  group_seq,
  margin_low,
  margin_high,
  fault_suppress
);
  input wire mclk;
  input wire rst;
  input wire op_wr;
  input wire [7:0] op_data;
  input wire op_group;
  input wire onoff_enable;
  input wire chan_enabled;
  input wire all_power_good;
  input wire pin_on;
  input wire pin_off;
  output reg [7:0] op_byte;
  output reg run_req;
  output reg off_immediate;
  output reg group_seq;
  output wire margin_low;
  output wire margin_high;
  output wire fault_suppress;

  reg [1:0] margin_reg;
  reg ignore_reg;
  wire wr_ok;
  wire margining;

  assign wr_ok = op_wr && chan_enabled;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      op_byte <= `PSOC_OP_RESET;
      run_req <= 1'b0;
      off_immediate <= 1'b0;
      group_seq <= 1'b0;
      margin_reg <= `PSOC_MARGIN_OFF;
      ignore_reg <= 1'b0;
    end else if (wr_ok) begin
      op_byte <= op_data;
      // Margin portion always applies; on/off only when enabled by config
      case (op_data)
        `PSOC_OP_LOW_IGN, `PSOC_OP_LOW_ACT: margin_reg <= `PSOC_MARGIN_LOW;
        `PSOC_OP_HIGH_IGN, `PSOC_OP_HIGH_ACT: margin_reg <= `PSOC_MARGIN_HIGH;
        `PSOC_OP_ON: margin_reg <= `PSOC_MARGIN_OFF;
        default: margin_reg <= margin_reg;
      endcase
      if (op_data[7]) begin
        ignore_reg <= (op_data[3:2] == 2'h1);
      end
      if (onoff_enable) begin
        group_seq <= op_group;
        case (op_data)
          `PSOC_OP_OFF_NOW: begin
            run_req <= 1'b0;
            off_immediate <= 1'b1;
          end
          `PSOC_OP_OFF_SOFT: begin
            run_req <= 1'b0;
            off_immediate <= 1'b0;
          end
          default: begin
            run_req <= 1'b1;
            off_immediate <= 1'b0;
          end
        endcase
      end
    end else if (chan_enabled && pin_off) begin
      run_req <= 1'b0;
      off_immediate <= 1'b0;
    end else if (chan_enabled && pin_on) begin
      run_req <= 1'b1;
    end
  end

  // Margining waits for every channel to reach power good
  assign margining = run_req && all_power_good && (margin_reg != `PSOC_MARGIN_OFF);
  assign margin_low = margining && (margin_reg == `PSOC_MARGIN_LOW);
  assign margin_high = margining && (margin_reg == `PSOC_MARGIN_HIGH);
  assign fault_suppress = margining && ignore_reg;
endmodule

// >>> verif/psoc_host_model.sv
/* Host model: one-byte commands on the command port.
   Assumes the bench clock and a done pulse one cycle after each command. */
`timescale 1ns/1ps
module psoc_host_model (input wire mclk, input wire cmd_done, input wire [7:0] cmd_rdata,
  output reg cmd_valid, output reg cmd_write, output reg [7:0] cmd_code,
  output reg [7:0] cmd_wdata);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h5A;
    cmd_wdata = 8'hA5;
  end
  task xfer(input w, input [7:0] c, input [7:0] d, output [7:0] r, output dn);
    begin
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_code <= c;
      cmd_wdata <= d;
      @(posedge mclk);
      cmd_valid <= 1'b0;
      // Idle lines never keep the old byte
      cmd_code <= ~c;
      cmd_wdata <= ~d;
      @(posedge mclk);
      r = cmd_rdata;
      dn = cmd_done;
    end
  endtask
endmodule

// >>> verif/psoc_top_chk.sv
/* Checker: command port and channel output relations.
   Assumes binding to the top; sees its ports only. */
`timescale 1ns/1ps
module psoc_top_chk #(parameter NCHAN = 16) (input wire mclk, input wire rst,
  input wire cmd_valid, input wire cmd_write, input wire [7:0] cmd_code,
  input wire [7:0] cmd_wdata, input wire cmd_done, input wire pin_on, input wire pin_off,
  input wire all_power_good, input wire [NCHAN-1:0] supply_enable_output,
  input wire [NCHAN-1:0] margin_low, input wire [NCHAN-1:0] margin_high,
  input wire [NCHAN-1:0] fault_suppress, input wire [3:0] sel_chan,
  input wire [1:0] sel_margin_dac_output, input wire cml_status, input wire alert_oe,
  input wire onoff_enable, input wire [NCHAN-1:0] chan_enabled, input wire sel_is_temp,
  input wire sel_is_all);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire pg_wr = cmd_valid && cmd_write && cmd_code == 8'h00;
  wire op_wr = cmd_valid && cmd_write && cmd_code == 8'h01;
  wire op_bad = !(cmd_wdata inside {8'h00, 8'h40, 8'h80, 8'h94, 8'h98, 8'hA4, 8'hA8});
  wire pg_res = cmd_wdata == 8'h10 || (cmd_wdata > 8'h15 && cmd_wdata != 8'hFF);
  wire one_ok = op_wr && onoff_enable && !sel_is_all && !sel_is_temp && chan_enabled[sel_chan];
  chk_off_now: assert property (one_ok && cmd_wdata == 8'h00 |=>
    !supply_enable_output[sel_chan]) else $error("off not taken");
  chk_on_plain: assert property (one_ok && cmd_wdata == 8'h80 |=>
    supply_enable_output[sel_chan] && !margin_low[sel_chan] && !margin_high[sel_chan])
    else $error("on not taken");
  chk_page_hold: assert property (!pg_wr |=> $stable(sel_chan))
    else $error("page moved");
  chk_done_follow: assert property (cmd_valid |=> cmd_done)
    else $error("done missing");
  chk_done_cause: assert property (cmd_done |-> $past(cmd_valid))
    else $error("done without command");
  chk_page_map: assert property (pg_wr && cmd_wdata < 8'h10 |=>
    sel_chan == $past(cmd_wdata[3:0]) && sel_margin_dac_output == $past(cmd_wdata[1:0]))
    else $error("page decode wrong");
  chk_reserved_page: assert property (pg_wr && pg_res |=> cml_status && alert_oe)
    else $error("reserved page not flagged");
  chk_bad_op: assert property (op_wr && op_bad |=> cml_status && alert_oe)
    else $error("invalid op not flagged");
  chk_margin_gate: assert property (|(margin_low | margin_high) |-> all_power_good)
    else $error("margin before power good");
  chk_suppress_scope: assert property ((fault_suppress & ~(margin_low | margin_high)) == '0)
    else $error("suppress outside margin");
  chk_margin_excl: assert property ((margin_low & margin_high) == '0)
    else $error("both margins");
  chk_hold_run: assert property (!cmd_valid && !pin_on && !pin_off |=>
    $stable(supply_enable_output)) else $error("run changed idle");
endmodule
bind psoc_top psoc_top_chk #(.NCHAN(NCHAN)) i_psoc_top_chk (.mclk(mclk), .rst(rst),
  .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
  .cmd_done(cmd_done), .pin_on(pin_on), .pin_off(pin_off), .all_power_good(all_power_good),
  .supply_enable_output(supply_enable_output), .margin_low(margin_low),
  .margin_high(margin_high), .fault_suppress(fault_suppress), .sel_chan(sel_chan),
  .sel_margin_dac_output(sel_margin_dac_output), .cml_status(cml_status),
  .alert_oe(alert_oe), .onoff_enable(onoff_enable), .chan_enabled(chan_enabled),
  .sel_is_temp(sel_is_temp), .sel_is_all(sel_is_all));

// >>> verif/psoc_tb_top.sv
/* Bench top: commands through the host model, outputs checked.
   Assumes a fixed seed; inputs change on the rising edge. */
`timescale 1ns/1ps
module psoc_tb_top;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg onoff_enable = 1'b1;
  reg [15:0] chan_enabled = 16'hFFFF;
  reg all_power_good = 1'b1;
  reg pin_on = 1'b0;
  reg pin_off = 1'b0;
  wire vld, wr, done, s_tint, s_temp, s_all, cml, al_o, al_oe;
  wire [7:0] code, wdata, rdata, s_dac, s_taddr;
  wire [15:0] en_o, offi, grp, mlo, mhi, fsup;
  wire [3:0] s_chan;
  wire [1:0] s_mdo;
  integer fail_count = 0;
  integer comparisons = 0;
  integer cyc = 0;
  integer i, k, ch;
  reg [31:0] rng = 32'd92;
  reg [7:0] rd, p, op, lastpg;
  reg [15:0] m, exp_en;
  reg dn, okp;
  reg [7:0] ops [0:6];
  always #2.5 mclk = ~mclk;
  psoc_top #(.NCHAN(16)) i_psoc_top (.mclk(mclk), .rst(rst), .cmd_valid(vld),
    .cmd_write(wr), .cmd_code(code), .cmd_wdata(wdata), .cmd_done(done), .cmd_rdata(rdata),
    .onoff_enable(onoff_enable), .chan_enabled(chan_enabled),
    .all_power_good(all_power_good), .pin_on(pin_on), .pin_off(pin_off),
    .supply_enable_output(en_o), .off_immediate(offi), .group_seq(grp), .margin_low(mlo),
    .margin_high(mhi), .fault_suppress(fsup), .sel_chan(s_chan), .sel_dac_addr(s_dac),
    .sel_margin_dac_output(s_mdo), .sel_temp_addr(s_taddr), .sel_temp_internal(s_tint),
    .sel_is_temp(s_temp), .sel_is_all(s_all), .cml_status(cml), .alert_o(al_o),
    .alert_oe(al_oe));
  psoc_host_model i_psoc_host_model (.mclk(mclk), .cmd_done(done), .cmd_rdata(rdata),
    .cmd_valid(vld), .cmd_write(wr), .cmd_code(code), .cmd_wdata(wdata));
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  function pg_ok(input [7:0] pg);
    pg_ok = pg < 8'h10 || (pg > 8'h10 && pg < 8'h16) || pg == 8'hFF;
  endfunction
  task complete_run;
    begin
      if (fail_count == 0 && comparisons > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("unexpected %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task cmd(input w, input [7:0] c, input [7:0] d);
    begin
      i_psoc_host_model.xfer(w, c, d, rd, dn);
      chk("done", dn, 1'b1);
    end
  endtask
  task clr;
    begin
      cmd(1'b1, 8'h03, 8'h00);
      chk("clear", {cml, al_oe, al_o}, 3'b000);
    end
  endtask
  // Cut a hang short
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      fail_count = fail_count + 1;
      complete_run;
    end
  end
  initial begin
    ops[0] = 8'h00;
    ops[1] = 8'h40;
    ops[2] = 8'h80;
    ops[3] = 8'h94;
    ops[4] = 8'h98;
    ops[5] = 8'hA4;
    ops[6] = 8'hA8;
    lastpg = 8'h00;
    exp_en = 16'h0000;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    chk("dac", s_dac, 8'h20);
    cmd(1'b0, 8'h00, 8'h00);
    chk("page", rd, 8'h00);
    for (i = 0; i < 24; i = i + 1) begin
      rng = xs(rng);
      p = i < 22 ? i : (i == 22 ? 8'hFF : 8'd22 + rng % 233);
      okp = pg_ok(p);
      cmd(1'b1, 8'h00, p);
      chk("cml", cml, !okp);
      if (okp) lastpg = p;
      if (p < 8'h10) chk("map", {s_chan, s_mdo, s_dac}, {p[3:0], p[1:0], p[3:2], 6'h20});
      if (okp && p > 8'h10) chk("sel", {s_temp, s_tint, s_all},
        {p != 8'hFF, p == 8'h11, p == 8'hFF});
      if (p > 8'h11 && p < 8'h16) chk("taddr", s_taddr, 8'h90 + (p - 8'h12) * 2);
      cmd(1'b0, 8'h00, 8'h00);
      chk("page", rd, lastpg);
      clr;
    end
    for (i = 0; i < 3; i = i + 1) begin
      rng = xs(rng);
      ch = rng % 16;
      cmd(1'b1, 8'h00, ch);
      for (k = 0; k < 7; k = k + 1) begin
        op = ops[(k + i) % 7];
        cmd(1'b1, 8'h01, op);
        exp_en[ch] = op[7];
        chk("run", en_o, exp_en);
        chk("mrg", {mlo[ch], mhi[ch], fsup[ch], grp[ch]},
          {op[4], op[5], op == 8'h94 || op == 8'hA4, 1'b0});
        if (!op[7]) chk("offi", offi[ch], op == 8'h00);
        cmd(1'b0, 8'h01, 8'h00);
        chk("opread", rd, op);
      end
    end
    cmd(1'b1, 8'h01, 8'hA8);
    exp_en[ch] = 1'b1;
    rng = xs(rng);
    cmd(1'b1, 8'h01, rng[7:0] | 8'h01);
    chk("bad", {cml, al_oe, en_o[ch], mhi[ch]}, 4'hF);
    clr;
    all_power_good <= 1'b0;
    cmd(1'b1, 8'h01, 8'h94);
    chk("pg", {en_o[ch], mlo[ch]}, 2'b10);
    all_power_good <= 1'b1;
    @(posedge mclk);
    chk("pg", mlo[ch], 1'b1);
    onoff_enable <= 1'b0;
    cmd(1'b1, 8'h01, 8'h00);
    cmd(1'b1, 8'h01, 8'hA4);
    chk("onoff", {en_o[ch], mhi[ch], mlo[ch]}, 3'b110);
    onoff_enable <= 1'b1;
    chan_enabled[ch] <= 1'b0;
    cmd(1'b1, 8'h01, 8'h00);
    chk("dis", en_o[ch], 1'b1);
    cmd(1'b1, 8'h00, 8'h11);
    cmd(1'b1, 8'h01, 8'h80);
    chk("tpage", {cml, en_o}, {1'b1, exp_en});
    clr;
    rng = xs(rng);
    m = rng[15:0];
    chan_enabled <= m;
    cmd(1'b1, 8'h00, 8'hFF);
    cmd(1'b1, 8'h01, 8'h80);
    exp_en = exp_en | m;
    chk("all", {en_o, grp & m}, {exp_en, m});
    cmd(1'b1, 8'h01, 8'h00);
    exp_en = exp_en & ~m;
    chk("all", en_o, exp_en);
    chan_enabled <= 16'hFFFF;
    pin_on <= 1'b1;
    @(posedge mclk);
    pin_on <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("pin", en_o, 16'hFFFF);
    pin_off <= 1'b1;
    @(posedge mclk);
    pin_off <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("pin", en_o, 16'h0000);
    complete_run;
  end
endmodule
